// ==== verif/core_model.sv ====
// behavioural core: holds the program counter and follows loads from the block
`timescale 1ns/1ps

module core_model (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_pc_load,
    input wire logic [15:0] i_pc_val,
    output logic [15:0] o_pc
);
    // ==========================================
    // program counter
    // parks between loads so saved values stay predictable
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pc <= 16'h0100;
        end else if (i_pc_load) begin
            o_pc <= i_pc_val;
        end
    end
endmodule // core_model

// ==== verif/cpu_interrupt_and_wake_logic_props.sv ====
// port assertions for the interrupt and wake block
`timescale 1ns/1ps
`include "irq_wake_defines.svh"

module cpu_interrupt_and_wake_logic_props (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_reti,
    input wire logic [2:0] i_reti_opt,
    input wire logic i_wdt_ovf,
    input wire logic i_brownout,
    input wire logic i_rst_pin,
    input wire logic o_take,
    input wire logic o_pc_load,
    input wire logic [7:0] o_speed,
    input wire logic o_clk_stop,
    input wire logic o_wdt_run,
    input wire logic o_rtt_run,
    input wire logic o_chip_reset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // ==========================================
    // assertions
    property p_take_gap; o_take |=> !o_take [*4]; endproperty
    a_take_gap: assert property (p_take_gap)
        else $error("entry repeated too soon");
    property p_take_load; o_take |-> o_pc_load; endproperty
    a_take_load: assert property (p_take_load)
        else $error("entry without program counter load");
    property p_reti_time; o_pc_load && !o_take |-> $past(i_reti, 3); endproperty
    a_reti_time: assert property (p_reti_time)
        else $error("return load not three cycles after return");
    property p_speed_keep;
        o_pc_load && !o_take && !$past(i_reti_opt[2], 3) |-> o_speed == $past(o_speed, 3);
    endproperty
    a_speed_keep: assert property (p_speed_keep)
        else $error("speed changed by return without restore option");
    property p_chip_rst;
        !$past(i_srst) |-> o_chip_reset == $past(i_wdt_ovf | i_brownout | i_rst_pin);
    endproperty
    a_chip_rst: assert property (p_chip_rst)
        else $error("chip reset does not follow its sources");
    property p_run_bits;
        i_wr && i_addr == `IRQ_OFS_CTRL |=> o_rtt_run == $past(i_wdata[`IRQ_CTRL_RTT_RUN])
            && o_wdt_run == $past(i_wdata[`IRQ_CTRL_WDT_RUN]);
    endproperty
    a_run_bits: assert property (p_run_bits)
        else $error("timer run outputs do not follow control write");
    property p_stop_bit; o_clk_stop == o_speed[`IRQ_SPD_STOP]; endproperty
    a_stop_bit: assert property (p_stop_bit)
        else $error("clock stop output differs from speed stop bit");
    property p_reset_speed; $fell(i_srst) |-> o_speed == `IRQ_SPD_RESET; endproperty
    a_reset_speed: assert property (p_reset_speed)
        else $error("speed not at reset value after reset");
    // ==========================================
    // covers
    c_take: cover property (o_take);
    c_return: cover property (o_pc_load && !o_take);
    c_chip: cover property (o_chip_reset);
endmodule // cpu_interrupt_and_wake_logic_props

bind cpu_interrupt_and_wake_logic cpu_interrupt_and_wake_logic_props u_props (.*);

// ==== verif/cpu_interrupt_and_wake_logic_tb.sv ====
// testbench of the interrupt and wake block
`timescale 1ns/1ps
`include "irq_wake_defines.svh"

`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); end end

module cpu_interrupt_and_wake_logic_tb;
    logic i_clk = 1'h0, i_srst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, i_pm_stall = 1'h0;
    logic i_reti = 1'h0, i_t0_tick = 1'h0, i_wdt_ovf = 1'h0, i_brownout = 1'h0;
    logic i_rst_pin = 1'h0, o_take, o_pc_load, o_clk_stop, o_wdt_run, o_rtt_run, o_chip_reset;
    logic [3:0] i_addr = 4'h0;
    logic [2:0] i_reti_opt = 3'h0;
    logic [7:0] i_wdata = 8'h00, i_evt = 8'h00, i_w = 8'h05, o_rdata, o_speed;
    logic [15:0] i_pc, o_pc_val;
    int failures = 0, n_compared = 0, n;

    cpu_interrupt_and_wake_logic #(.SRC_SWITCH_CYC(16'h0002), .WAKE_UNIT_CYC(16'h0001)) u_dut (.*);
    core_model u_core (.i_clk(i_clk), .i_srst(i_srst), .i_pc_load(o_pc_load),
        .i_pc_val(o_pc_val), .o_pc(i_pc));

    initial begin
        forever #2 i_clk = ~i_clk;
    end
    // ==========================================
    // bus and core tasks; each ends just after an edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'h0;
        #1;
        `CHK("read data", exp, o_rdata)
    endtask
    task automatic wait_evt(input bit on_load, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge i_clk);
            #1;
            cnt++;
        end while (((on_load ? o_pc_load : o_take) !== 1'h1) && cnt < lim);
    endtask
    // latency counts from the edge that sets the flag: two request stages,
    // one detect edge, then the entry count, so a plain entry shows 6
    task automatic expect_entry(input int lat, input logic [15:0] vec, input logic [7:0] spd);
        wait_evt(0, 20, n);
        `CHK("entry cycles", lat, n)
        `CHK("entry vector", vec, o_pc_val)
        rd(`IRQ_OFS_CTRL, 8'h03);
        rd(`IRQ_OFS_CUR_SPEED, spd);
    endtask
    task automatic reti(input logic [2:0] opt);
        i_reti <= 1'h1;
        i_reti_opt <= opt;
        @(posedge i_clk);
        i_reti <= 1'h0;
        wait_evt(1, 10, n);
        `CHK("return cycles", 2, n)
        `CHK("return pc", 16'h0100, o_pc_val)
        rd(`IRQ_OFS_CTRL, 8'h83);
    endtask
    task automatic pulse(input logic [7:0] e);
        i_evt <= e;
        @(posedge i_clk);
        i_evt <= 8'h00;
        #1;
    endtask
    task automatic end_sim();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        repeat (8) @(posedge i_clk);
        i_srst <= 1'h0;
        #1;
        rd(`IRQ_OFS_CUR_SPEED, `IRQ_SPD_RESET);
        wr(`IRQ_OFS_VEC_HIGH, 8'h12);
        wr(`IRQ_OFS_VEC_LOW, 8'h34);
        wr(`IRQ_OFS_SRC_EN, 8'h01);
        wr(`IRQ_OFS_IRQ_SPEED, 8'h91);
        wr(`IRQ_OFS_TIMER0, 8'h10);
        wr(`IRQ_OFS_CONFIG, 8'h01);
        wr(`IRQ_OFS_CTRL, 8'h83);
        `CHK("watchdog run", 1'h1, o_wdt_run)
        wr(`IRQ_OFS_FLAG_SET, 8'h01);
        expect_entry(6, 16'h1234, 8'h91);
        wr(`IRQ_OFS_CTRL, 8'h03);
        rd(`IRQ_OFS_CTRL, 8'h03);
        wr(`IRQ_OFS_FLAG, 8'h01);
        repeat (2) @(posedge i_clk);
        reti(3'h7);
        rd(`IRQ_OFS_CUR_SPEED, 8'h93);
        rd(`IRQ_OFS_TIMER0, 8'h15);
        rd(`IRQ_OFS_VEC_LOW, 8'h35);
        rd(`IRQ_OFS_VEC_HIGH, 8'h12);
        wait_evt(0, 12, n);
        `CHK("no reentry", 12, n)
        // global enable off holds a pending flag back
        wr(`IRQ_OFS_CTRL, 8'h03);
        wr(`IRQ_OFS_FLAG_SET, 8'h01);
        wait_evt(0, 10, n);
        `CHK("gated request", 10, n)
        wr(`IRQ_OFS_CTRL, 8'h83);
        expect_entry(6, 16'h1235, 8'h91);
        wr(`IRQ_OFS_FLAG, 8'h01);
        repeat (2) @(posedge i_clk);
        reti(3'h0);
        rd(`IRQ_OFS_CUR_SPEED, 8'h91);
        rd(`IRQ_OFS_VEC_LOW, 8'h35);
        rd(`IRQ_OFS_TIMER0, 8'h15);
        // stall in mainline, then leave the source masked
        i_pm_stall <= 1'h1;
        wr(`IRQ_OFS_FLAG_SET, 8'h01);
        expect_entry(9, 16'h1235, 8'h91);
        i_pm_stall <= 1'h0;
        wr(`IRQ_OFS_SRC_EN, 8'h00);
        reti(3'h0);
        wait_evt(0, 12, n);
        `CHK("masked source", 12, n)
        // port source with synchronizer on
        wr(`IRQ_OFS_CONFIG, 8'h00);
        wr(`IRQ_OFS_FLAG, 8'h01);
        pulse(8'h02);
        rd(`IRQ_OFS_FLAG, 8'h00);
        wr(`IRQ_OFS_PERIPH_EN, 8'h02);
        wr(`IRQ_OFS_SRC_EN, 8'h02);
        pulse(8'h02);
        expect_entry(8, 16'h1235, 8'h91);
        wr(`IRQ_OFS_FLAG, 8'h02);
        repeat (2) @(posedge i_clk);
        reti(3'h0);
        i_brownout <= 1'h1;
        @(posedge i_clk);
        i_brownout <= 1'h0;
        #1;
        `CHK("chip reset", 1'h1, o_chip_reset)
        // entry speed on another clock source adds the switch time (2 here)
        wr(`IRQ_OFS_CONFIG, 8'h01);
        wr(`IRQ_OFS_SRC_EN, 8'h01);
        wr(`IRQ_OFS_IRQ_SPEED, 8'h81);
        wr(`IRQ_OFS_FLAG_SET, 8'h01);
        expect_entry(8, 16'h1235, 8'h81);
        end_sim();
    end
    // ==========================================
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #40000;
        failures++;
        end_sim();
    end
endmodule // cpu_interrupt_and_wake_logic_tb

// ==== verilog/cpu_interrupt_and_wake_logic.sv ====
// interrupt control, speed switch on entry, return handling and clock stop wake
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "irq_wake_defines.svh"

// Contract
// - taking interrupt clears global enable
// - return instruction sets global enable again
// - control bit 7 write sets global enable
// - clearing enable inside handler changes nothing
// - enable in handler nests, two-deep shadow
// - latency ends when handler enters execute
// - port source adds two sync cycles
// - program memory stall adds three cycles
// - entry shadows speed, loads interrupt speed
// - same source entry takes three cycles
// - source change adds slower clock period
// - oscillator or pll restart adds startup delay
// - return option bit 2 restores speed
// - return option bit 1 reloads vector
// - return option bit 0 adds w to timer0
// - return takes one plus two cycles
// - disabled peripheral cannot set its flag
// - software set flag interrupts regardless
// - interrupt logic and timers run when stopped
// - port and timer events wake without reset
// - watchdog, brownout, reset pin reset chip
// - request needs flag, source and global enable
// - request drops two cycles after clear
// - entry saves pc, jumps to vector
module cpu_interrupt_and_wake_logic #(
    parameter int NSRC = 8,
    parameter logic [7:0] PORT_MASK = 8'h0F,
    parameter logic [7:0] RTT_MASK = 8'h10,
    parameter logic [15:0] SRC_SWITCH_CYC = 16'h0008,
    parameter logic [15:0] WAKE_UNIT_CYC = 16'h0010
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [7:0] i_evt,
    input wire logic [15:0] i_pc,
    input wire logic i_pm_stall,
    input wire logic i_reti,
    input wire logic [2:0] i_reti_opt,
    input wire logic [7:0] i_w,
    input wire logic i_t0_tick,
    input wire logic i_wdt_ovf,
    input wire logic i_brownout,
    input wire logic i_rst_pin,
    output logic o_take,
    output logic o_pc_load,
    output logic [15:0] o_pc_val,
    output logic [7:0] o_speed,
    output logic o_clk_stop,
    output logic o_wdt_run,
    output logic o_rtt_run,
    output logic o_chip_reset
);
    // ==========================================
    // helpers
    function automatic logic [15:0] wake_delay(input logic [2:0] code);
        wake_delay = 16'((17'(code) + 17'h0_0001) * 17'(WAKE_UNIT_CYC));
    endfunction

    irq_wake_pkg::irq_regs_t r_ff;
    irq_wake_pkg::irq_regs_t nxt_r;

    logic [7:0] pend;
    logic [15:0] extra;
    logic [15:0] pc_inc;
    logic nest;

    // ==========================================
    // next state
    always_comb begin
        nxt_r = r_ff;
        nxt_r.take = 1'b0;
        nxt_r.pc_load = 1'b0;
        nxt_r.chip_rst = 1'b0;
        nxt_r.rdata = 8'h00;
        pend = r_ff.flag & r_ff.src_en;
        extra = `IRQ_ENTRY_CYC - 16'h0001;
        pc_inc = i_pc + 16'h0001;
        nest = r_ff.depth != 2'h0;

        // request gating and two stage drop after a clear
        nxt_r.req_p1 = (|pend) & r_ff.global_irq_enable;
        nxt_r.req_p2 = r_ff.req_p1;

        // software writes
        if (i_wr) begin
            if (i_addr == `IRQ_OFS_CTRL) begin
                // in a handler gie is already low, so clearing is a no-op
                nxt_r.global_irq_enable = i_wdata[`IRQ_CTRL_GIE];
                nxt_r.tmr_run = i_wdata[1:0];
            end else if (i_addr == `IRQ_OFS_FLAG) begin
                nxt_r.flag = r_ff.flag & ~i_wdata;
            end else if (i_addr == `IRQ_OFS_FLAG_SET) begin
                nxt_r.flag = r_ff.flag | i_wdata;
            end else if (i_addr == `IRQ_OFS_SRC_EN) begin
                nxt_r.src_en = i_wdata;
            end else if (i_addr == `IRQ_OFS_PERIPH_EN) begin
                nxt_r.periph_en = i_wdata;
            end else if (i_addr == `IRQ_OFS_IRQ_SPEED) begin
                nxt_r.irq_spd = i_wdata;
            end else if (i_addr == `IRQ_OFS_VEC_HIGH) begin
                nxt_r.vec[15:8] = i_wdata;
            end else if (i_addr == `IRQ_OFS_VEC_LOW) begin
                nxt_r.vec[7:0] = i_wdata;
            end else if (i_addr == `IRQ_OFS_TIMER0) begin
                nxt_r.t0 = i_wdata;
            end else if (i_addr == `IRQ_OFS_CONFIG) begin
                nxt_r.cfg = i_wdata;
            end
        end

        // hardware set wins over a clear in the same cycle
        nxt_r.flag = nxt_r.flag | (i_evt & r_ff.periph_en);

        if (i_t0_tick) begin
            nxt_r.t0 = nxt_r.t0 + 8'h01;
        end

        // clock stop: flags keep collecting while the core clock is gone
        if (r_ff.cur_spd[`IRQ_SPD_STOP] && (|(pend & (PORT_MASK | RTT_MASK)))) begin
            nxt_r.cur_spd[`IRQ_SPD_STOP] = 1'b0;
        end
        nxt_r.chip_rst = i_wdt_ovf | i_brownout | i_rst_pin;

        case (r_ff.st)
            irq_wake_pkg::S_IDLE: begin
                if (i_reti && nest) begin
                    nxt_r.global_irq_enable = 1'b1;
                    nxt_r.depth = r_ff.depth - 2'h1;
                    nxt_r.pc_val = r_ff.shd_pc[0];
                    nxt_r.shd_pc[0] = r_ff.shd_pc[1];
                    nxt_r.shd_spd[0] = r_ff.shd_spd[1];
                    if (i_reti_opt[`IRQ_RETI_SPEED]) begin
                        nxt_r.cur_spd = r_ff.shd_spd[0];
                    end
                    if (i_reti_opt[`IRQ_RETI_VEC]) begin
                        nxt_r.vec = pc_inc;
                    end
                    if (i_reti_opt[`IRQ_RETI_T0]) begin
                        nxt_r.t0 = nxt_r.t0 + i_w;
                    end
                    nxt_r.cnt = `IRQ_RETI_CYC - 16'h0001;
                    nxt_r.st = irq_wake_pkg::S_RETI;
                end else if (r_ff.req_p2 && r_ff.global_irq_enable && r_ff.depth != 2'h2) begin
                    // a third level would overrun the two-deep shadow
                    nxt_r.global_irq_enable = 1'b0;
                    nxt_r.depth = r_ff.depth + 2'h1;
                    nxt_r.shd_pc[1] = r_ff.shd_pc[0];
                    nxt_r.shd_pc[0] = i_pc;
                    nxt_r.shd_spd[1] = r_ff.shd_spd[0];
                    nxt_r.shd_spd[0] = r_ff.cur_spd;
                    nxt_r.cur_spd = r_ff.irq_spd;
                    if (|(pend & PORT_MASK) && !r_ff.cfg[`IRQ_CFG_SYNC]) begin
                        extra = extra + `IRQ_SYNC_CYC;
                    end
                    if (i_pm_stall) begin
                        extra = extra + `IRQ_STALL_CYC;
                    end
                    if (r_ff.cur_spd[`IRQ_SPD_SRC] != r_ff.irq_spd[`IRQ_SPD_SRC]) begin
                        extra = extra + SRC_SWITCH_CYC;
                    end
                    // with both restarting only the oscillator delay counts
                    if (r_ff.cur_spd[`IRQ_SPD_OSC_OFF] && !r_ff.irq_spd[`IRQ_SPD_OSC_OFF]) begin
                        extra = extra + wake_delay(r_ff.cfg[`IRQ_CFG_OSC_LO +: 3]);
                    end else if (r_ff.cur_spd[`IRQ_SPD_PLL_OFF]
                                 && !r_ff.irq_spd[`IRQ_SPD_PLL_OFF]) begin
                        extra = extra + wake_delay(r_ff.cfg[`IRQ_CFG_PLL_LO +: 3]);
                    end
                    nxt_r.cnt = extra;
                    nxt_r.st = irq_wake_pkg::S_ENTRY;
                end
            end
            irq_wake_pkg::S_ENTRY: begin
                if (r_ff.cnt == 16'h0000) begin
                    nxt_r.take = 1'b1;
                    nxt_r.pc_load = 1'b1;
                    nxt_r.pc_val = r_ff.vec;
                    nxt_r.st = irq_wake_pkg::S_IDLE;
                end else begin
                    nxt_r.cnt = r_ff.cnt - 16'h0001;
                end
            end
            irq_wake_pkg::S_RETI: begin
                if (r_ff.cnt == 16'h0001) begin
                    nxt_r.pc_load = 1'b1;
                    nxt_r.st = irq_wake_pkg::S_IDLE;
                end else begin
                    nxt_r.cnt = r_ff.cnt - 16'h0001;
                end
            end
            default: begin
                nxt_r.st = irq_wake_pkg::S_IDLE;
            end
        endcase

        // reads answer the cycle after the strobe
        if (i_rd) begin
            if (i_addr == `IRQ_OFS_CTRL) begin
                nxt_r.rdata = {r_ff.global_irq_enable, 5'h00, r_ff.tmr_run};
            end else if (i_addr == `IRQ_OFS_FLAG || i_addr == `IRQ_OFS_FLAG_SET) begin
                nxt_r.rdata = r_ff.flag;
            end else if (i_addr == `IRQ_OFS_SRC_EN) begin
                nxt_r.rdata = r_ff.src_en;
            end else if (i_addr == `IRQ_OFS_PERIPH_EN) begin
                nxt_r.rdata = r_ff.periph_en;
            end else if (i_addr == `IRQ_OFS_IRQ_SPEED) begin
                nxt_r.rdata = r_ff.irq_spd;
            end else if (i_addr == `IRQ_OFS_CUR_SPEED) begin
                nxt_r.rdata = r_ff.cur_spd;
            end else if (i_addr == `IRQ_OFS_VEC_HIGH) begin
                nxt_r.rdata = r_ff.vec[15:8];
            end else if (i_addr == `IRQ_OFS_VEC_LOW) begin
                nxt_r.rdata = r_ff.vec[7:0];
            end else if (i_addr == `IRQ_OFS_SAVED_HIGH) begin
                nxt_r.rdata = r_ff.shd_pc[0][15:8];
            end else if (i_addr == `IRQ_OFS_SAVED_LOW) begin
                nxt_r.rdata = r_ff.shd_pc[0][7:0];
            end else if (i_addr == `IRQ_OFS_TIMER0) begin
                nxt_r.rdata = r_ff.t0;
            end else if (i_addr == `IRQ_OFS_CONFIG) begin
                nxt_r.rdata = r_ff.cfg;
            end else if (i_addr == `IRQ_OFS_STATUS) begin
                nxt_r.rdata = {4'h0, r_ff.req_p2, r_ff.depth, r_ff.cur_spd[`IRQ_SPD_STOP]};
            end else begin
                nxt_r.rdata = 8'h00;
            end
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            r_ff <= '0;
            r_ff.cur_spd <= `IRQ_SPD_RESET;
            r_ff.shd_spd <= '0;
            r_ff.cfg <= `IRQ_CFG_RESET;
            r_ff.st <= irq_wake_pkg::S_IDLE;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ==========================================
    // outputs
    assign o_rdata = r_ff.rdata;
    assign o_take = r_ff.take;
    assign o_pc_load = r_ff.pc_load;
    assign o_pc_val = r_ff.pc_val;
    assign o_speed = r_ff.cur_spd;
    assign o_clk_stop = r_ff.cur_spd[`IRQ_SPD_STOP];
    assign o_wdt_run = r_ff.tmr_run[`IRQ_CTRL_WDT_RUN];
    assign o_rtt_run = r_ff.tmr_run[`IRQ_CTRL_RTT_RUN];
    assign o_chip_reset = r_ff.chip_rst;
endmodule // cpu_interrupt_and_wake_logic

// ==== verilog/irq_wake_defines.svh ====
// offsets, field positions, reset values and timing counts of the interrupt block
`ifndef IRQ_WAKE_DEFINES_SVH
`define IRQ_WAKE_DEFINES_SVH
// ==========================================
// register offsets
`define IRQ_OFS_CTRL 4'h0
`define IRQ_OFS_FLAG 4'h1
`define IRQ_OFS_FLAG_SET 4'h2
`define IRQ_OFS_SRC_EN 4'h3
`define IRQ_OFS_PERIPH_EN 4'h4
`define IRQ_OFS_IRQ_SPEED 4'h5
`define IRQ_OFS_CUR_SPEED 4'h6
`define IRQ_OFS_VEC_HIGH 4'h7
`define IRQ_OFS_VEC_LOW 4'h8
`define IRQ_OFS_SAVED_HIGH 4'h9
`define IRQ_OFS_SAVED_LOW 4'hA
`define IRQ_OFS_TIMER0 4'hB
`define IRQ_OFS_CONFIG 4'hC
`define IRQ_OFS_STATUS 4'hD
// ==========================================
// control register fields
`define IRQ_CTRL_GIE 7
`define IRQ_CTRL_WDT_RUN 1
`define IRQ_CTRL_RTT_RUN 0
// ==========================================
// speed setting fields
`define IRQ_SPD_PLL_OFF 7
`define IRQ_SPD_OSC_OFF 6
`define IRQ_SPD_STOP 5
`define IRQ_SPD_SRC 4
`define IRQ_SPD_RESET 8'h93
// ==========================================
// config word fields
`define IRQ_CFG_SYNC 0
`define IRQ_CFG_PLL_LO 1
`define IRQ_CFG_OSC_LO 4
`define IRQ_CFG_RESET 8'h00
// ==========================================
// return option bits
`define IRQ_RETI_SPEED 2
`define IRQ_RETI_VEC 1
`define IRQ_RETI_T0 0
// ==========================================
// timing counts in core cycles
`define IRQ_SYNC_CYC 16'h0002
`define IRQ_STALL_CYC 16'h0003
`define IRQ_ENTRY_CYC 16'h0003
`define IRQ_RETI_CYC 16'h0003
`endif

// ==== verilog/irq_wake_pkg.sv ====
// types of the interrupt and wake block
package irq_wake_pkg;
    typedef enum logic [1:0] {
        S_IDLE,
        S_ENTRY,
        S_RETI
    } irq_state_t;

    typedef struct packed {
        logic global_irq_enable;
        logic [1:0] tmr_run;
        logic [7:0] flag;
        logic [7:0] src_en;
        logic [7:0] periph_en;
        logic [7:0] irq_spd;
        logic [7:0] cur_spd;
        logic [1:0][7:0] shd_spd;
        logic [1:0][15:0] shd_pc;
        logic [1:0] depth;
        logic [15:0] vec;
        logic [7:0] t0;
        logic [7:0] cfg;
        logic req_p1;
        logic req_p2;
        irq_state_t st;
        logic [15:0] cnt;
        logic take;
        logic pc_load;
        logic [15:0] pc_val;
        logic chip_rst;
        logic [7:0] rdata;
    } irq_regs_t;
endpackage
